// File: rtl/tgw_pkg.sv
// Purpose: Timer group constants
// Assumes: 25 MHz clock, 32-bit register bus
// Notes: Byte offsets, one word per register
package tgw_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clock and timing
  localparam int unsigned CLK_KHZ = 25000;           // System clock rate in kHz
  localparam int unsigned BOOT_TIMEOUT_MS = 1000;    // Flash boot guard time in ms
  localparam int unsigned BOOT_TIMEOUT_CYC = BOOT_TIMEOUT_MS * CLK_KHZ;
  localparam logic [1:0] BOOT_SAMPLE_CNT = 2'h3;     // Edges after reset before strap read

  ////////////////////////////////////////////////////////////////////////////
  // Block sizes
  localparam int unsigned NUM_TIMERS = 4;            // General purpose timers
  localparam int unsigned NUM_WDT = 3;               // Two main, one RTC domain
  localparam int unsigned NUM_STAGES = 4;            // Stages per watchdog
  localparam int unsigned RTC_WDT_IDX = 2;           // Index of RTC domain watchdog
  localparam int unsigned BOOT_MAIN_IDX = 0;         // Main watchdog armed at boot
  localparam int unsigned NUM_IRQ = 7;               // Four timers, three watchdogs

  ////////////////////////////////////////////////////////////////////////////
  // Address: bit 7 space, 6:5 unit, 4:2 word
  localparam int unsigned ADDR_W = 8;
  localparam logic [1:0] UNIT_IRQ = 2'h3;            // Unit slot 3 in watchdog space

  // Timer words
  localparam logic [2:0] T_CFG = 3'h0;               // 0x00 control
  localparam logic [2:0] T_CNT_LO = 3'h1;            // 0x04 live count low
  localparam logic [2:0] T_CNT_HI = 3'h2;            // 0x08 live count high
  localparam logic [2:0] T_LOAD_LO = 3'h3;           // 0x0c reload value low
  localparam logic [2:0] T_LOAD_HI = 3'h4;           // 0x10 reload value high
  localparam logic [2:0] T_ALARM_LO = 3'h5;          // 0x14 alarm value low
  localparam logic [2:0] T_ALARM_HI = 3'h6;          // 0x18 alarm value high
  localparam logic [2:0] T_RELOAD = 3'h7;            // 0x1c write forces reload

  // Timer control fields
  localparam int unsigned TC_EN = 0;                 // Counting enabled
  localparam int unsigned TC_UP = 1;                 // Count upward
  localparam int unsigned TC_AUTO = 2;               // Reload on alarm
  localparam int unsigned TC_EDGE = 3;               // Edge type timer interrupt
  localparam int unsigned TC_ALARM_EN = 4;           // Alarm compare enabled
  localparam int unsigned TC_DIV_LSB = 16;           // Prescaler divider field
  localparam logic [31:0] TCFG_RESET = 32'h0000_0002;

  // Watchdog words (0x80 + 0x20 * index)
  localparam logic [2:0] W_CFG = 3'h0;               // 0x00 control, stage readback
  localparam logic [2:0] W_STAGE0 = 3'h1;            // 0x04..0x10 stage timeouts
  localparam logic [2:0] W_FEED = 3'h5;              // 0x14 any write feeds
  localparam logic [2:0] W_KEY = 3'h6;               // 0x18 protection key
  localparam logic [2:0] W_CNT = 3'h7;               // 0x1c expiry counter

  // Watchdog control fields
  localparam int unsigned WC_EN = 0;                 // Watchdog running
  localparam int unsigned WC_STG_LSB = 1;            // Four stage enables
  localparam int unsigned WC_ACT_LSB = 5;            // Two action bits per stage
  localparam int unsigned WC_CUR_LSB = 13;           // Current stage, read only
  localparam int unsigned WC_DONE = 15;              // All stages spent, read only
  localparam logic [31:0] WCFG_RW_MASK = 32'h0000_1fff;

  // Stage actions
  localparam logic [1:0] ACT_IRQ = 2'h0;
  localparam logic [1:0] ACT_CPU = 2'h1;
  localparam logic [1:0] ACT_CORE = 2'h2;
  localparam logic [1:0] ACT_SYS = 2'h3;

  // Interrupt words at 0xe0
  localparam logic [2:0] I_STATUS = 3'h0;            // 0xe0 sticky status
  localparam logic [2:0] I_ENABLE = 3'h1;            // 0xe4 enable
  localparam logic [2:0] I_CLEAR = 3'h2;             // 0xe8 write one to clear
  localparam int unsigned IRQ_WDT_LSB = 4;           // Watchdog bits follow timers

endpackage

// File: rtl/tgw_top.sv
// Purpose: Timer group: four 64-bit timers and three four-stage watchdogs
// Assumes: Avalon-MM slave with waitrequest, synchronous active high reset
// Notes: Register writes take effect at the edge where waitrequest is low
//
// Contract
// RL1: Four timers, prescaler feeding 64-bit counter
// RL2: 16-bit prescaler, divide ratio 2 to 65536
// RL3: Counter counts up or down by configuration
// RL4: Halt holds count, resume continues from it
// RL5: Optional auto reload on alarm, forced reload
// RL6: Alarm interrupt, level or edge type
// RL7: Three watchdogs: two main, one RTC domain
// RL8: Four stages, each configured or disabled separately
// RL9: Per stage timeout on 32-bit expiry counter
// RL10: Expired enabled stage performs its configured action
// RL11: Actions: interrupt, processor, core, system reset
// RL12: Only RTC domain watchdog may reset system
// RL13: Flash boot starts RTC and first main watchdog
// RL14: Boot not finished in time reboots system
// RL15: Watchdog configuration write protected by key
// RL16: After action, advance to next enabled stage
// RL17: Feeding clears counter, restarts at first stage
`timescale 1ns/1ns

module tgw_top #(
  parameter int unsigned BOOT_TIMEOUT_CYC = tgw_pkg::BOOT_TIMEOUT_CYC,
  parameter logic [31:0] UNLOCK_KEY = 32'h5a5a_c3c3  // Arbitrary key value
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // Avalon-MM register slave
  input wire logic [tgw_pkg::ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Boot strap pin, high while booting from flash
  input wire logic flash_boot_in,
  // Interrupts
  output logic irq_out,
  output logic [tgw_pkg::NUM_TIMERS-1:0] timer_irq_out,
  // Reset requests, one cycle pulses
  output logic cpu_rst_req_out,
  output logic core_rst_req_out,
  output logic sys_rst_req_out
);

  localparam int unsigned NT = tgw_pkg::NUM_TIMERS;
  localparam int unsigned NW = tgw_pkg::NUM_WDT;
  localparam int unsigned NS = tgw_pkg::NUM_STAGES;
  localparam int unsigned NI = tgw_pkg::NUM_IRQ;

  ////////////////////////////////////////////////////////////////////////////
  // Whole block state
  typedef struct packed {
    logic [NT-1:0][31:0] tcfg;       // Timer controls
    logic [NT-1:0][63:0] tcnt;       // Timer counts
    logic [NT-1:0][63:0] tload;      // Reload values
    logic [NT-1:0][63:0] talarm;     // Alarm values
    logic [NT-1:0][15:0] tpre;       // Prescaler counts
    logic [NT-1:0] tpulse;           // Edge type interrupt pulses
    logic [NW-1:0][31:0] wcfg;       // Watchdog controls
    logic [NW-1:0][NS-1:0][31:0] wto; // Stage timeouts
    logic [NW-1:0][31:0] wcnt;       // Expiry counters
    logic [NW-1:0][1:0] wstage;      // Current stage
    logic [NW-1:0] wdone;            // No stage left to run
    logic [NW-1:0] wopen;            // Protection lifted
    logic [NI-1:0] istat;            // Sticky interrupt status
    logic [NI-1:0] ien;              // Interrupt enables
    logic cpu_rst;                   // Reset request pulses
    logic core_rst;
    logic sys_rst;
    logic ack;                       // Bus answer cycle
    logic [31:0] rdata;              // Read data
    logic boot_s1;                   // Strap synchroniser
    logic boot_s2;
    logic [1:0] settle;              // Edges since reset
    logic boot_seen;                 // Strap already sampled
  } tgw_state_s;

  tgw_state_s s_q;
  tgw_state_s s_d;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Byte enable merge of a write word
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Divider field to ratio: 0 is 65536, 1 is 2
  function automatic logic [16:0] div_ratio(input logic [15:0] div);
    logic [16:0] r;
    if (div == 16'h0000) begin
      r = 17'h1_0000;
    end else if (div == 16'h0001) begin
      r = 17'h0_0002;
    end else begin
      r = {1'b0, div};
    end
    return r;
  endfunction

  // First enabled stage from an index; bit 2 if none
  function automatic logic [2:0] stage_from(input logic [NS-1:0] en, input logic [2:0] from);
    logic [2:0] r;
    r = 3'h4;
    for (int i = NS - 1; i >= 0; i--) begin
      if (en[i] && (3'(i) >= from)) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  logic bus_req;
  logic bus_wr;
  logic in_wdt;
  logic [1:0] unit;
  logic [2:0] word;
  logic [31:0] wdata;

  always_comb begin
    bus_req = avs_read_in | avs_write_in;
    bus_wr = avs_write_in & s_q.ack;  // Write lands at the answer edge
    in_wdt = avs_address_in[7];
    unit = avs_address_in[6:5];
    word = avs_address_in[4:2];
    wdata = avs_writedata_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic [16:0] ratio;
    logic [63:0] nxt;
    logic [2:0] first;
    logic [2:0] after;
    logic [NS-1:0] sen;
    logic [1:0] act;
    logic [NI-1:0] iset;
    logic [NI-1:0] iclr;
    logic [31:0] rd;
    ratio = 17'h0;
    nxt = 64'h0;
    first = 3'h0;
    after = 3'h0;
    sen = '0;
    act = 2'h0;
    iset = '0;
    iclr = '0;
    rd = 32'h0;
    s_d = s_q;
    s_d.cpu_rst = 1'b0;
    s_d.core_rst = 1'b0;
    s_d.sys_rst = 1'b0;
    s_d.tpulse = '0;

    // Strap synchroniser and one-time boot arming
    s_d.boot_s1 = flash_boot_in;
    s_d.boot_s2 = s_q.boot_s1;
    if (s_q.settle != tgw_pkg::BOOT_SAMPLE_CNT) begin
      s_d.settle = s_q.settle + 2'h1;
    end else if (!s_q.boot_seen) begin
      s_d.boot_seen = 1'b1;
      if (s_q.boot_s2) begin
        // Stage 0 only, system reset from the RTC domain watchdog
        s_d.wcfg[tgw_pkg::RTC_WDT_IDX] = 32'(1) << tgw_pkg::WC_EN; // RL13
        s_d.wcfg[tgw_pkg::RTC_WDT_IDX][tgw_pkg::WC_STG_LSB] = 1'b1;
        s_d.wcfg[tgw_pkg::RTC_WDT_IDX][tgw_pkg::WC_ACT_LSB +: 2] = tgw_pkg::ACT_SYS; // RL14
        s_d.wto[tgw_pkg::RTC_WDT_IDX][0] = 32'(BOOT_TIMEOUT_CYC); // RL14
        // First main watchdog resets the core
        s_d.wcfg[tgw_pkg::BOOT_MAIN_IDX] = 32'(1) << tgw_pkg::WC_EN; // RL13
        s_d.wcfg[tgw_pkg::BOOT_MAIN_IDX][tgw_pkg::WC_STG_LSB] = 1'b1;
        s_d.wcfg[tgw_pkg::BOOT_MAIN_IDX][tgw_pkg::WC_ACT_LSB +: 2] = tgw_pkg::ACT_CORE;
        s_d.wto[tgw_pkg::BOOT_MAIN_IDX][0] = 32'(BOOT_TIMEOUT_CYC);
      end
    end

    // Timers: prescaler tick, count, alarm
    for (int t = 0; t < NT; t++) begin // RL1
      ratio = div_ratio(s_q.tcfg[t][tgw_pkg::TC_DIV_LSB +: 16]); // RL2
      if (s_q.tcfg[t][tgw_pkg::TC_EN]) begin // RL4
        if ({1'b0, s_q.tpre[t]} == ratio - 17'h1) begin
          s_d.tpre[t] = 16'h0;
          // Direction picked by control bit
          nxt = s_q.tcfg[t][tgw_pkg::TC_UP] ? s_q.tcnt[t] + 64'h1
                                             : s_q.tcnt[t] - 64'h1; // RL3
          s_d.tcnt[t] = nxt;
          if (s_q.tcfg[t][tgw_pkg::TC_ALARM_EN] && (nxt == s_q.talarm[t])) begin
            iset[t] = 1'b1; // RL6
            s_d.tpulse[t] = 1'b1; // RL6
            if (s_q.tcfg[t][tgw_pkg::TC_AUTO]) begin
              s_d.tcnt[t] = s_q.tload[t]; // RL5
            end
          end
        end else begin
          s_d.tpre[t] = s_q.tpre[t] + 16'h1;
        end
      end
      // Halted timer keeps both count and prescaler phase
    end

    // Watchdogs: stage timing and actions
    for (int w = 0; w < NW; w++) begin // RL7
      sen = s_q.wcfg[w][tgw_pkg::WC_STG_LSB +: NS];
      if (s_q.wcfg[w][tgw_pkg::WC_EN] && !s_q.wdone[w]) begin
        // Stage period reached
        if ({1'b0, s_q.wcnt[w]} + 33'h1 >= {1'b0, s_q.wto[w][s_q.wstage[w]]}) begin // RL9
          s_d.wcnt[w] = 32'h0;
          act = s_q.wcfg[w][tgw_pkg::WC_ACT_LSB + 2 * s_q.wstage[w] +: 2];
          if (sen[s_q.wstage[w]]) begin // RL8
            case (act) // RL11
              tgw_pkg::ACT_IRQ: iset[tgw_pkg::IRQ_WDT_LSB + w] = 1'b1; // RL10
              tgw_pkg::ACT_CPU: s_d.cpu_rst = 1'b1; // RL10
              tgw_pkg::ACT_CORE: s_d.core_rst = 1'b1; // RL10
              tgw_pkg::ACT_SYS: begin
                // Inert on main watchdogs
                if (w == tgw_pkg::RTC_WDT_IDX) begin
                  s_d.sys_rst = 1'b1; // RL12
                end
              end
              default: s_d.cpu_rst = 1'b0;
            endcase
          end
          // Move on to the next enabled stage, stop after the last
          after = stage_from(sen, {1'b0, s_q.wstage[w]} + 3'h1); // RL16
          if (after[2]) begin
            s_d.wdone[w] = 1'b1; // RL16
          end else begin
            s_d.wstage[w] = after[1:0]; // RL16
          end
        end else begin
          s_d.wcnt[w] = s_q.wcnt[w] + 32'h1; // RL9
        end
      end
    end

    // Register writes
    if (bus_wr) begin
      if (!in_wdt) begin
        // Timer space
        case (word)
          tgw_pkg::T_CFG: s_d.tcfg[unit] = be_merge(s_q.tcfg[unit], wdata, avs_byteenable_in);
          tgw_pkg::T_LOAD_LO: begin
            s_d.tload[unit][31:0] = be_merge(s_q.tload[unit][31:0], wdata, avs_byteenable_in);
          end
          tgw_pkg::T_LOAD_HI: begin
            s_d.tload[unit][63:32] = be_merge(s_q.tload[unit][63:32], wdata,
                                              avs_byteenable_in);
          end
          tgw_pkg::T_ALARM_LO: begin
            s_d.talarm[unit][31:0] = be_merge(s_q.talarm[unit][31:0], wdata,
                                              avs_byteenable_in);
          end
          tgw_pkg::T_ALARM_HI: begin
            s_d.talarm[unit][63:32] = be_merge(s_q.talarm[unit][63:32], wdata,
                                               avs_byteenable_in);
          end
          tgw_pkg::T_RELOAD: begin
            // Forced reload wins over a same cycle count step
            s_d.tcnt[unit] = s_q.tload[unit]; // RL5
            s_d.tpre[unit] = 16'h0;
          end
          default: s_d.tpre[unit] = s_d.tpre[unit];
        endcase
      end else if (unit != tgw_pkg::UNIT_IRQ) begin
        // Watchdog space
        case (word)
          tgw_pkg::W_CFG: begin
            if (s_q.wopen[unit]) begin // RL15
              s_d.wcfg[unit] = be_merge(s_q.wcfg[unit], wdata, avs_byteenable_in)
                               & tgw_pkg::WCFG_RW_MASK;
              sen = s_d.wcfg[unit][tgw_pkg::WC_STG_LSB +: NS];
              first = stage_from(sen, 3'h0);
              s_d.wcnt[unit] = 32'h0;
              s_d.wstage[unit] = first[1:0];
              s_d.wdone[unit] = first[2];
            end
          end
          tgw_pkg::W_FEED: begin
            // Feed restarts from the first enabled stage
            first = stage_from(s_q.wcfg[unit][tgw_pkg::WC_STG_LSB +: NS], 3'h0);
            s_d.wcnt[unit] = 32'h0; // RL17
            s_d.wstage[unit] = first[1:0]; // RL17
            s_d.wdone[unit] = first[2]; // RL17
          end
          tgw_pkg::W_KEY: s_d.wopen[unit] = (wdata == UNLOCK_KEY); // RL15
          tgw_pkg::W_CNT: s_d.wopen[unit] = s_d.wopen[unit];
          default: begin
            // Stage timeout words
            if (s_q.wopen[unit]) begin // RL15
              s_d.wto[unit][word[1:0] - 2'h1] = be_merge(s_q.wto[unit][word[1:0] - 2'h1],
                                                         wdata, avs_byteenable_in);
            end
          end
        endcase
      end else begin
        // Interrupt control
        case (word)
          tgw_pkg::I_ENABLE: s_d.ien = wdata[NI-1:0];
          tgw_pkg::I_CLEAR: iclr = wdata[NI-1:0];
          default: iclr = '0;
        endcase
      end
    end

    // Sticky status: a new event beats a same cycle clear
    s_d.istat = (s_q.istat & ~iclr) | iset;

    // Read mux, sampled in the waiting cycle
    if (!in_wdt) begin
      case (word)
        tgw_pkg::T_CFG: rd = s_q.tcfg[unit];
        tgw_pkg::T_CNT_LO: rd = s_q.tcnt[unit][31:0];
        tgw_pkg::T_CNT_HI: rd = s_q.tcnt[unit][63:32];
        tgw_pkg::T_LOAD_LO: rd = s_q.tload[unit][31:0];
        tgw_pkg::T_LOAD_HI: rd = s_q.tload[unit][63:32];
        tgw_pkg::T_ALARM_LO: rd = s_q.talarm[unit][31:0];
        tgw_pkg::T_ALARM_HI: rd = s_q.talarm[unit][63:32];
        default: rd = 32'h0;
      endcase
    end else if (unit != tgw_pkg::UNIT_IRQ) begin
      case (word)
        tgw_pkg::W_CFG: begin
          rd = s_q.wcfg[unit];
          rd[tgw_pkg::WC_CUR_LSB +: 2] = s_q.wstage[unit];
          rd[tgw_pkg::WC_DONE] = s_q.wdone[unit];
        end
        tgw_pkg::W_FEED: rd = 32'h0;
        tgw_pkg::W_KEY: rd = {31'h0, s_q.wopen[unit]};
        tgw_pkg::W_CNT: rd = s_q.wcnt[unit];
        default: rd = s_q.wto[unit][word[1:0] - 2'h1];
      endcase
    end else begin
      case (word)
        tgw_pkg::I_STATUS: rd = {{(32-NI){1'b0}}, s_q.istat};
        tgw_pkg::I_ENABLE: rd = {{(32-NI){1'b0}}, s_q.ien};
        default: rd = 32'h0;
      endcase
    end

    // One wait cycle, then the answer cycle
    s_d.ack = bus_req & ~s_q.ack;
    if (bus_req && !s_q.ack) begin
      s_d.rdata = avs_read_in ? rd : 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      s_q <= '0;
      for (int t = 0; t < NT; t++) begin
        s_q.tcfg[t] <= tgw_pkg::TCFG_RESET;
      end
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  always_comb begin
    avs_waitrequest_out = (avs_read_in | avs_write_in) & ~s_q.ack;
    avs_readdata_out = s_q.rdata;
    irq_out = |(s_q.istat & s_q.ien);
    cpu_rst_req_out = s_q.cpu_rst;
    core_rst_req_out = s_q.core_rst;
    sys_rst_req_out = s_q.sys_rst;
    for (int t = 0; t < NT; t++) begin
      // Level: masked status; edge: alarm pulse
      timer_irq_out[t] = s_q.tcfg[t][tgw_pkg::TC_EDGE] ? s_q.tpulse[t]
                         : (s_q.istat[t] & s_q.ien[t]); // RL6
    end
  end

endmodule

// File: dv/tgw_asserts.sv
// Purpose: Port checks of the timer group
// Assumes: Strap steady in reset, no writes during boot
// Notes: Boot checks end at the first write after reset
`timescale 1ns/1ns
module tgw_asserts #(
  parameter int unsigned BOOT_TIMEOUT_CYC = 50
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic sys_rst_in,
  // Register bus handshake
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic avs_waitrequest_out,
  // Strap, interrupts and reset requests
  input wire logic flash_boot_in,
  input wire logic irq_out,
  input wire logic [tgw_pkg::NUM_TIMERS-1:0] timer_irq_out,
  input wire logic cpu_rst_req_out,
  input wire logic core_rst_req_out,
  input wire logic sys_rst_req_out
);
  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] age_q; // Cycles since reset release
  logic live_q; // No register write since reset
  logic sys_seen_q; // System reset request seen
  logic core_seen_q; // Core reset request seen
  // Boot tracking helper
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      age_q <= 32'h0;
      live_q <= 1'b1;
      sys_seen_q <= 1'b0;
      core_seen_q <= 1'b0;
    end else begin
      age_q <= age_q + 32'h1;
      live_q <= live_q & ~avs_write_in;
      sys_seen_q <= sys_seen_q | sys_rst_req_out;
      core_seen_q <= core_seen_q | core_rst_req_out;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  a_read_one_wait: assert property ($rose(avs_read_in) |-> avs_waitrequest_out ##1
    !avs_waitrequest_out) else $error("read wait wrong");
  a_write_one_wait: assert property ($rose(avs_write_in) |-> avs_waitrequest_out ##1
    !avs_waitrequest_out) else $error("write wait wrong");
  a_idle_no_wait: assert property (!avs_read_in && !avs_write_in |->
    !avs_waitrequest_out) else $error("wait without request");
  a_quiet_release: assert property ($fell(sys_rst_in) |-> !irq_out &&
    timer_irq_out == 4'h0 && !cpu_rst_req_out && !core_rst_req_out && !sys_rst_req_out)
    else $error("output active after reset");
  a_sys_one_pulse: assert property (sys_rst_req_out |=> !sys_rst_req_out)
    else $error("long system request");
  a_boot_not_early: assert property (live_q && age_q < BOOT_TIMEOUT_CYC |->
    !sys_rst_req_out && !core_rst_req_out) else $error("boot guard early");
  a_boot_fires: assert property (live_q && flash_boot_in &&
    age_q == BOOT_TIMEOUT_CYC + 12 |-> sys_seen_q && core_seen_q)
    else $error("boot guard silent");
  a_no_strap_quiet: assert property (live_q && !flash_boot_in |->
    !sys_rst_req_out && !core_rst_req_out && !cpu_rst_req_out)
    else $error("action without boot");
  // Main scenarios reached
  c_sys_req: cover property (sys_rst_req_out);
  c_irq: cover property (irq_out);
  c_cpu_then_core: cover property (cpu_rst_req_out ##[1:40] core_rst_req_out);
endmodule
bind tgw_top tgw_asserts #(.BOOT_TIMEOUT_CYC(BOOT_TIMEOUT_CYC)) i_tgw_asserts (
  .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in), .avs_waitrequest_out(avs_waitrequest_out),
  .flash_boot_in(flash_boot_in), .irq_out(irq_out), .timer_irq_out(timer_irq_out),
  .cpu_rst_req_out(cpu_rst_req_out), .core_rst_req_out(core_rst_req_out),
  .sys_rst_req_out(sys_rst_req_out));

// File: dv/tb.sv
// Purpose: Bench of the timer group
// Assumes: Shortened boot guard
// Notes: Outputs judged at falling edges after a wait, else at rising edges
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin bad_count++; \
  $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module tb;
  localparam int unsigned BOOT = 50; // Shortened boot guard
  logic mclk_in, sys_rst_in, avs_read_in, avs_write_in, flash_boot_in;
  logic [7:0] avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out, rdat, a;
  logic [3:0] avs_byteenable_in, timer_irq_out;
  logic avs_waitrequest_out, irq_out, cpu_rst_req_out, core_rst_req_out, sys_rst_req_out;
  int bad_count, n_compared, n_cpu, n_core, n_sys;
  logic [4:0] evs; // Awaitable outputs
  assign evs = {timer_irq_out[1], sys_rst_req_out, core_rst_req_out, cpu_rst_req_out, irq_out};
  tgw_top #(.BOOT_TIMEOUT_CYC(BOOT), .UNLOCK_KEY(32'h5a5a_c3c3)) i_tgw_top (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .flash_boot_in(flash_boot_in), .irq_out(irq_out), .timer_irq_out(timer_irq_out),
    .cpu_rst_req_out(cpu_rst_req_out), .core_rst_req_out(core_rst_req_out),
    .sys_rst_req_out(sys_rst_req_out));
  ////////////////////////////////////////////////////////////////////////////
  // Clock at 25 MHz
  initial begin
    mclk_in = 1'b0;
    forever #20 mclk_in = ~mclk_in;
  end
  // Count reset request pulses
  always @(posedge mclk_in) begin
    if (cpu_rst_req_out === 1'b1) n_cpu++;
    if (core_rst_req_out === 1'b1) n_core++;
    if (sys_rst_req_out === 1'b1) n_sys++;
  end
  ////////////////////////////////////////////////////////////////////////////
  // One Avalon-MM transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    int n;
    avs_address_in <= ad;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    n = 0;
    do begin
      @(negedge mclk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 20);
    // Answer edge: write lands, read data taken
    @(posedge mclk_in);
    rdat = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    @(posedge mclk_in);
    if (n >= 20) bad_count++;
  endtask
  task automatic put(input logic [7:0] ad, input logic [31:0] d);
    bus(1'b1, ad, d);
  endtask
  task automatic get(input logic [7:0] ad);
    bus(1'b0, ad, 32'h0);
  endtask
  // Bounded wait on an output, ends at a falling edge
  task automatic wait_ev(input int w, input int lim);
    int n;
    n = 0;
    while (evs[w] !== 1'b1 && n < lim) begin
      @(negedge mclk_in);
      n++;
    end
    `CHK("awaited output", 1'b1, evs[w])
  endtask
  task automatic do_reset(input logic boot);
    @(posedge mclk_in);
    sys_rst_in <= 1'b1;
    flash_boot_in <= boot;
    repeat (16) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    @(posedge mclk_in);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Boot guard with and without the strap
  task automatic t_boot();
    int c;
    do_reset(1'b1);
    wait_ev(3, BOOT + 40);
    `CHK("core request at boot", 1'b1, core_rst_req_out)
    repeat (20) @(posedge mclk_in);
    do_reset(1'b0);
    c = n_sys + n_core;
    repeat (BOOT + 30) @(posedge mclk_in);
    `CHK("no boot action", c, n_sys + n_core)
    $display("boot test done");
  endtask
  // Timer one: alarm, mask, halt, prescale, direction, reloads
  task automatic t_timer();
    put(8'h34, 32'h5);
    put(8'he4, 32'h2);
    put(8'h20, 32'h0002_0013);
    wait_ev(0, 100);
    `CHK("timer line", 4'h2, timer_irq_out)
    @(posedge mclk_in);
    put(8'he4, 32'h0);
    `CHK("masked irq", 1'b0, irq_out)
    put(8'he4, 32'h2);
    `CHK("sticky irq", 1'b1, irq_out)
    put(8'he8, 32'h2);
    `CHK("cleared irq", 1'b0, irq_out)
    put(8'h20, 32'h0002_0002);
    get(8'h24);
    a = rdat;
    repeat (10) @(posedge mclk_in);
    get(8'h24);
    `CHK("held count", a, rdat)
    put(8'h2c, 32'h100);
    put(8'h3c, 32'h0);
    get(8'h24);
    `CHK("forced reload", 32'h100, rdat)
    put(8'h20, 32'h0004_0003);
    repeat (40) @(posedge mclk_in);
    get(8'h24);
    `CHK("up by four", 1'b1, rdat >= 32'h109 && rdat <= 32'h10b)
    put(8'h20, 32'h0004_0000);
    put(8'h3c, 32'h0);
    put(8'h20, 32'h0004_0001);
    repeat (40) @(posedge mclk_in);
    get(8'h24);
    `CHK("down by four", 1'b1, rdat >= 32'hf5 && rdat <= 32'hf7)
    put(8'h34, 32'h102);
    put(8'h20, 32'h0002_0017);
    repeat (50) @(posedge mclk_in);
    get(8'h24);
    `CHK("auto reload bound", 1'b1, rdat < 32'h102)
    // Edge type: one cycle pulse per alarm
    put(8'h20, 32'h0002_001f);
    wait_ev(4, 40);
    @(negedge mclk_in);
    `CHK("edge pulse ends", 1'b0, timer_irq_out[1])
    get(8'hec);
    `CHK("unmapped word", 32'h0, rdat)
    $display("timer test done");
  endtask
  // Watchdogs: lock, stage order, feed, system action
  task automatic t_wdt();
    int c;
    put(8'h80, 32'h3);
    get(8'h80);
    `CHK("locked cfg", 32'h0, rdat)
    put(8'h98, 32'h5a5a_c3c3);
    put(8'h84, 32'ha);
    put(8'h8c, 32'h8);
    put(8'h90, 32'h8);
    put(8'he4, 32'h10);
    c = n_core;
    put(8'h80, 32'h121b);
    wait_ev(0, 40);
    wait_ev(1, 40);
    `CHK("core after cpu", c, n_core)
    wait_ev(2, 40);
    @(posedge mclk_in);
    get(8'h80);
    `CHK("all stages spent", 1'b1, rdat[15])
    put(8'h94, 32'h0);
    get(8'h80);
    `CHK("restart at first", 3'h0, rdat[15:13])
    put(8'h98, 32'h0);
    put(8'h80, 32'h0);
    get(8'h80);
    `CHK("relocked cfg", 1'b1, rdat[0])
    put(8'h98, 32'h5a5a_c3c3);
    c = n_sys;
    put(8'h80, 32'h63);
    repeat (30) @(posedge mclk_in);
    `CHK("main no system reset", c, n_sys)
    put(8'hd8, 32'h5a5a_c3c3);
    put(8'hc4, 32'ha);
    put(8'hc0, 32'h63);
    wait_ev(3, 40);
    $display("watchdog test done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge mclk_in);
    bad_count++;
    give_verdict();
  end
  // Main sequence
  initial begin
    sys_rst_in = 1'b1;
    flash_boot_in = 1'b1;
    avs_read_in = 1'b0;
    avs_write_in = 1'b0;
    avs_address_in = 8'h0;
    avs_writedata_in = 32'h0;
    avs_byteenable_in = 4'hf;
    t_boot();
    t_timer();
    t_wdt();
    give_verdict();
  end
endmodule
